// file: rtl/pbpu_consts.svh
/*
 * constants for the port b pull-up control block: register indices and
 * byte addresses, field positions, reset values and bus response codes.
 * assumes it is included by bare name from the package and the modules.
 */
`ifndef PBPU_CONSTS_SVH
`define PBPU_CONSTS_SVH

// register indices as printed; byte address is four times the index
`define PBPU_IDX_DATA 6'h01
`define PBPU_IDX_DIR 6'h05
`define PBPU_IDX_PULL 6'h0c
`define PBPU_ADDR_DATA ({`PBPU_IDX_DATA, 2'b00})
`define PBPU_ADDR_DIR ({`PBPU_IDX_DIR, 2'b00})
`define PBPU_ADDR_PULL ({`PBPU_IDX_PULL, 2'b00})

// field layout and reset values
`define PBPU_BYTE_MSB 7
`define PBPU_RST_PULL 8'h00
`define PBPU_RST_DIR 8'h00
`define PBPU_RST_DATA 8'h00
`define PBPU_ZERO_HI 24'h000000
`define PBPU_RST_ADDR 8'h00
`define PBPU_RST_BYTE 8'h00
`define PBPU_NO_PINS 8'h00
`define PBPU_ALL_PINS 8'hff

// axi response codes
`define PBPU_RESP_OKAY 2'h0
`define PBPU_RESP_SLVERR 2'h2

`endif

// file: rtl/pbpu_pkg.sv
/*
 * types shared by the port b pull-up control block.
 * assumes pbpu_consts.svh sits in the include path.
 */
`include "pbpu_consts.svh"

package pbpu_pkg;
	// one port-wide byte, one bit per pin
	typedef logic [`PBPU_BYTE_MSB:0] pbpu_byte_t;
	// axi response code
	typedef logic [1:0] pbpu_resp_t;
	// register bus address (byte address)
	typedef logic [7:0] pbpu_addr_t;
endpackage : pbpu_pkg

// file: rtl/pbpu_pad_if.sv
/*
 * interface between the register core and the pad logic of port b.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface pbpu_pad_if;
	pbpu_pkg::pbpu_byte_t latch; // stored output latch bits
	pbpu_pkg::pbpu_byte_t dir; // direction bits, 1 = output
	pbpu_pkg::pbpu_byte_t pull; // pull-up enable bits
	pbpu_pkg::pbpu_byte_t level; // synchronised pin levels

	// register side
	modport core (output latch, output dir, output pull, input level);
	// pad side
	modport pad (input latch, input dir, input pull, output level);
endinterface : pbpu_pad_if

// file: rtl/pbpu_pads.sv
/*
 * pad logic for the eight port b pins: input synchroniser, output buffer
 * enable and pull-up gating.
 * assumes pin inputs are asynchronous and register bits come from CLK flops.
 */
`timescale 1ns/1ps
`include "pbpu_consts.svh"

module pbpu_pads (
	// clock, reset, enable
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_pull,
	// register side
	pbpu_pad_if.pad regs
);
	pbpu_pkg::pbpu_byte_t meta_r; // first synchroniser stage
	pbpu_pkg::pbpu_byte_t sync_r; // second synchroniser stage

	// two-flop synchroniser on the raw pin levels
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_r <= `PBPU_RST_DATA;
			sync_r <= `PBPU_RST_DATA;
		end else if (ce) begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	assign regs.level = sync_r;

	// output value always follows the latch; only the enable gates it
	assign pin_out = regs.latch;
	// output buffer on only for pins set as outputs; inputs without the pull-up float
	assign pin_oe = regs.dir;
	// pull-up only for input pins whose enable bit is set
	assign pin_pull = regs.pull & ~regs.dir;

	// an output pin never has its pull-up on
	out_no_pull_a: assert property (@(posedge clk) disable iff (srst)
		(pin_oe & pin_pull) == `PBPU_NO_PINS)
		else $error("pull-up active on a driven pin");

	// a cleared enable bit keeps the pull-up off in any direction
	pull_off_a: assert property (@(posedge clk) disable iff (srst)
		(pin_pull & ~regs.pull) == `PBPU_NO_PINS)
		else $error("pull-up active with its enable bit clear");

	// enabled input pins have the pull-up on
	pull_input_a: assert property (@(posedge clk) disable iff (srst)
		(pin_pull | regs.dir | ~regs.pull) == `PBPU_ALL_PINS)
		else $error("enabled input pin lacks its pull-up");

	// plain input pins are neither driven nor pulled
	input_hiz_a: assert property (@(posedge clk) disable iff (srst)
		((pin_oe | pin_pull) & ~regs.dir & ~regs.pull) == `PBPU_NO_PINS)
		else $error("plain input pin is not high impedance");
endmodule : pbpu_pads

// file: rtl/pbpu_top.sv
/*
 * port b pull-up control block: data latch, direction and pull-up enable
 * registers behind an axi4-lite slave, plus the pad control for eight pins.
 * assumes a single clock CLK, a synchronous reset and asynchronous pins.
 */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pbpu_consts.svh"

module pbpu_top (
	// clock, reset, enable
	input wire logic CLK,
	input wire logic SRST,
	input wire logic CE,
	// axi write address
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [7:0] AWADDR,
	input wire logic [2:0] AWPROT,
	// axi write data
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	// axi write response
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	// axi read address
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [7:0] ARADDR,
	input wire logic [2:0] ARPROT,
	// axi read data
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	// port b pins
	input wire logic [7:0] PB_IN,
	output logic [7:0] PB_OUT,
	output logic [7:0] PB_OE,
	output logic [7:0] PB_PULL
);
	pbpu_pad_if pads (); // register-to-pad bundle

	pbpu_pkg::pbpu_byte_t latch_r; // port b data latch
	pbpu_pkg::pbpu_byte_t dir_r; // port b direction bits
	pbpu_pkg::pbpu_byte_t pull_r; // port b pull enable bits
	logic aw_full_r; // write address held
	logic w_full_r; // write data held
	pbpu_pkg::pbpu_addr_t aw_addr_r; // held write address
	pbpu_pkg::pbpu_byte_t w_data_r; // held low write byte
	logic w_strb_r; // held low byte lane strobe
	logic bvalid_r; // write response pending
	pbpu_pkg::pbpu_resp_t bresp_r; // write response code
	logic rvalid_r; // read data pending
	pbpu_pkg::pbpu_byte_t rdata_r; // read byte
	pbpu_pkg::pbpu_resp_t rresp_r; // read response code
	logic wr_go; // perform the held write this cycle
	logic wr_hit; // held write address is mapped
	logic ar_go; // read address taken this cycle
	logic ar_hit; // read address is mapped
	pbpu_pkg::pbpu_byte_t rd_nxt; // byte the read will return

	// pad control and pin synchroniser
	pbpu_pads u_pads (
		.clk(CLK),
		.srst(SRST),
		.ce(CE),
		.pin_in(PB_IN),
		.pin_out(PB_OUT),
		.pin_oe(PB_OE),
		.pin_pull(PB_PULL),
		.regs(pads.pad)
	);

	assign pads.latch = latch_r;
	assign pads.dir = dir_r;
	assign pads.pull = pull_r;

	// channel readiness; nothing is taken while the enable is low
	assign AWREADY = CE & ~aw_full_r;
	assign WREADY = CE & ~w_full_r;
	assign ARREADY = CE & ~rvalid_r;
	assign BVALID = bvalid_r;
	assign BRESP = bresp_r;
	assign RVALID = rvalid_r;
	assign RDATA = {`PBPU_ZERO_HI, rdata_r};
	assign RRESP = rresp_r;

	// write fires once both halves are held and no response is pending
	assign wr_go = CE & aw_full_r & w_full_r & ~bvalid_r;
	assign wr_hit = (aw_addr_r == `PBPU_ADDR_DATA) | (aw_addr_r == `PBPU_ADDR_DIR)
		| (aw_addr_r == `PBPU_ADDR_PULL);
	assign ar_go = ARVALID & ARREADY;
	assign ar_hit = (ARADDR == `PBPU_ADDR_DATA) | (ARADDR == `PBPU_ADDR_DIR)
		| (ARADDR == `PBPU_ADDR_PULL);

	// read mux: input pins show the synchronised level, outputs show the latch
	always_comb begin
		rd_nxt = `PBPU_RST_BYTE;
		if (ARADDR == `PBPU_ADDR_DATA) begin
			rd_nxt = (dir_r & latch_r) | (~dir_r & pads.level);
		end else if (ARADDR == `PBPU_ADDR_DIR) begin
			rd_nxt = dir_r;
		end else if (ARADDR == `PBPU_ADDR_PULL) begin
			rd_nxt = pull_r;
		end
	end

	// write address capture, freed when the write is performed
	always_ff @(posedge CLK) begin
		if (SRST) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= `PBPU_RST_ADDR;
		end else if (CE) begin
			if (AWVALID & AWREADY) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= AWADDR;
			end else if (wr_go) begin
				aw_full_r <= 1'b0;
			end
		end
	end

	// write data capture, independent of the address channel
	always_ff @(posedge CLK) begin
		if (SRST) begin
			w_full_r <= 1'b0;
			w_data_r <= `PBPU_RST_BYTE;
			w_strb_r <= 1'b0;
		end else if (CE) begin
			if (WVALID & WREADY) begin
				w_full_r <= 1'b1;
				w_data_r <= WDATA[`PBPU_BYTE_MSB:0];
				w_strb_r <= WSTRB[0];
			end else if (wr_go) begin
				w_full_r <= 1'b0;
			end
		end
	end

	// write response, slverr for unmapped addresses
	always_ff @(posedge CLK) begin
		if (SRST) begin
			bvalid_r <= 1'b0;
			bresp_r <= `PBPU_RESP_OKAY;
		end else if (CE) begin
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? `PBPU_RESP_OKAY : `PBPU_RESP_SLVERR;
			end else if (BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// data latch: always writable, whatever the direction
	always_ff @(posedge CLK) begin
		if (SRST) begin
			latch_r <= `PBPU_RST_DATA;
		end else if (CE & wr_go & w_strb_r & (aw_addr_r == `PBPU_ADDR_DATA)) begin
			latch_r <= w_data_r;
		end
	end

	// direction register, all inputs after reset
	always_ff @(posedge CLK) begin
		if (SRST) begin
			dir_r <= `PBPU_RST_DIR;
		end else if (CE & wr_go & w_strb_r & (aw_addr_r == `PBPU_ADDR_DIR)) begin
			dir_r <= w_data_r;
		end
	end

	// pull-up enable register, each bit stored independently
	always_ff @(posedge CLK) begin
		if (SRST) begin
			pull_r <= `PBPU_RST_PULL;
		end else if (CE & wr_go & w_strb_r & (aw_addr_r == `PBPU_ADDR_PULL)) begin
			pull_r <= w_data_r;
		end
	end

	// read channel, one outstanding read
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rvalid_r <= 1'b0;
			rdata_r <= `PBPU_RST_BYTE;
			rresp_r <= `PBPU_RESP_OKAY;
		end else if (CE) begin
			if (ar_go) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_nxt;
				rresp_r <= ar_hit ? `PBPU_RESP_OKAY : `PBPU_RESP_SLVERR;
			end else if (RREADY) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// a pull enable write lands exactly as written
	pull_write_a: assert property (@(posedge CLK) disable iff (SRST)
		(wr_go & w_strb_r & (aw_addr_r == `PBPU_ADDR_PULL)) |=> (pull_r == $past(w_data_r)))
		else $error("pull enable write not stored");

	// reset clears every pull enable
	pull_reset_a: assert property (@(posedge CLK)
		SRST |=> (pull_r == `PBPU_RST_PULL) && (PB_PULL == `PBPU_NO_PINS))
		else $error("pull enables not cleared by reset");

	// a latch write leaves the output enables and pull-ups of every pin unchanged
	latch_input_a: assert property (@(posedge CLK) disable iff (SRST)
		(wr_go & (aw_addr_r == `PBPU_ADDR_DATA)) |=> $stable(PB_OE) && $stable(PB_PULL))
		else $error("latch write changed pin mode");

	// data read returns pin level for inputs and latch for outputs
	read_mux_a: assert property (@(posedge CLK) disable iff (SRST)
		(ar_go & (ARADDR == `PBPU_ADDR_DATA)) |=> RVALID && (RDATA[`PBPU_BYTE_MSB:0] ==
		(($past(dir_r) & $past(latch_r)) | (~$past(dir_r) & $past(pads.level)))))
		else $error("port data read returned wrong value");

	// direction reads back as written
	dir_read_a: assert property (@(posedge CLK) disable iff (SRST)
		(ar_go & (ARADDR == `PBPU_ADDR_DIR)) |=> (RDATA[`PBPU_BYTE_MSB:0] == $past(dir_r)))
		else $error("direction read mismatch");
endmodule : pbpu_top

// file: verif/test_port_b_pullup_control.sv
/*
 * self-checking bench for the port b pull-up control block: axi4-lite
 * register access, pull-up gating, direction and data latch readback.
 * assumes pbpu_top with CE driven by the bench and the constants header in the path.
 */
`timescale 1ns/1ps
`include "pbpu_consts.svh"

module test_port_b_pullup_control;
	// clock and reset
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic CE = 1'b1; // clock enable, dropped only in the reset scenario
	logic [3:0] strb_sel = 4'hf; // byte lanes the write task offers
	// axi channels
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h00000000;
	logic [31:0] RDATA;
	logic [3:0] WSTRB = 4'h0;
	logic [1:0] BRESP, RRESP;
	// pins
	logic [7:0] PB_IN = 8'h00;
	logic [7:0] PB_OUT, PB_OE, PB_PULL;
	int miscompares = 0; // mismatch count
	int compares = 0; // comparison count

	pbpu_top DUT (.CLK(CLK), .SRST(SRST), .CE(CE),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .AWPROT(3'h0),
		.WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR), .ARPROT(3'h0),
		.RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.PB_IN(PB_IN), .PB_OUT(PB_OUT), .PB_OE(PB_OE), .PB_PULL(PB_PULL));

	// 25 mhz clock
	initial begin
		forever #20 CLK = ~CLK;
	end

	// compare tasks, one per result kind
	task automatic chk8(input string what, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk8
	task automatic chk32(input string what, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk32

	// pins are sampled mid-cycle, where they have settled
	task automatic pins(input logic [7:0] pull, input logic [7:0] oe);
		@(negedge CLK);
		chk8("pull-up pins", PB_PULL, pull);
		chk8("output enables", PB_OE, oe);
	endtask : pins

	// one write: address and data offered together, each released when taken
	task automatic wr(input pbpu_pkg::pbpu_addr_t a, input pbpu_pkg::pbpu_byte_t d,
		input pbpu_pkg::pbpu_resp_t er);
		logic aw_t, w_t, b_t;
		logic [1:0] r;
		@(posedge CLK);
		AWVALID <= 1'b1;
		AWADDR <= a;
		WVALID <= 1'b1;
		WDATA <= {24'h000000, d};
		WSTRB <= strb_sel;
		BREADY <= 1'b1;
		aw_t = 1'b0;
		w_t = 1'b0;
		while (!(aw_t && w_t)) begin
			@(negedge CLK);
			if (AWREADY === 1'b1) aw_t = 1'b1;
			if (WREADY === 1'b1) w_t = 1'b1;
			@(posedge CLK);
			if (aw_t) AWVALID <= 1'b0;
			if (w_t) WVALID <= 1'b0;
		end
		b_t = 1'b0;
		while (!b_t) begin
			@(negedge CLK);
			b_t = (BVALID === 1'b1);
			r = BRESP;
			@(posedge CLK);
		end
		BREADY <= 1'b0;
		chk8("write response", {6'h00, r}, {6'h00, er});
	endtask : wr

	// one read, data and response judged against expectations
	task automatic rd(input pbpu_pkg::pbpu_addr_t a, input pbpu_pkg::pbpu_byte_t ed,
		input pbpu_pkg::pbpu_resp_t er);
		logic ar_t, r_t;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge CLK);
		ARVALID <= 1'b1;
		ARADDR <= a;
		RREADY <= 1'b1;
		ar_t = 1'b0;
		while (!ar_t) begin
			@(negedge CLK);
			ar_t = (ARREADY === 1'b1);
			@(posedge CLK);
		end
		ARVALID <= 1'b0;
		r_t = 1'b0;
		while (!r_t) begin
			@(negedge CLK);
			r_t = (RVALID === 1'b1);
			d = RDATA;
			r = RRESP;
			if (!r_t) @(posedge CLK);
		end
		@(posedge CLK);
		RREADY <= 1'b0;
		chk32("read data", d, {24'h000000, ed});
		chk8("read response", {6'h00, r}, {6'h00, er});
	endtask : rd

	// reset values of the pull and direction registers and of the pins
	task automatic t_reset();
		rd(`PBPU_ADDR_PULL, 8'h00, `PBPU_RESP_OKAY);
		rd(`PBPU_ADDR_DIR, 8'h00, `PBPU_RESP_OKAY);
		pins(8'h00, 8'h00);
	endtask : t_reset

	// each enable bit alone, all pins inputs
	task automatic t_bits();
		for (int i = 0; i < 8; i++) begin
			wr(`PBPU_ADDR_PULL, 8'h01 << i, `PBPU_RESP_OKAY);
			rd(`PBPU_ADDR_PULL, 8'h01 << i, `PBPU_RESP_OKAY);
			pins(8'h01 << i, 8'h00);
		end
	endtask : t_bits

	// outputs force the pull-up off, inputs bring it back
	task automatic t_dir();
		wr(`PBPU_ADDR_PULL, 8'hff, `PBPU_RESP_OKAY);
		wr(`PBPU_ADDR_DIR, 8'ha5, `PBPU_RESP_OKAY);
		pins(8'h5a, 8'ha5);
		rd(`PBPU_ADDR_DIR, 8'ha5, `PBPU_RESP_OKAY);
		wr(`PBPU_ADDR_DIR, 8'h00, `PBPU_RESP_OKAY);
		pins(8'hff, 8'h00);
	endtask : t_dir

	// enables clear: no pull-up in either direction, inputs float
	task automatic t_off();
		wr(`PBPU_ADDR_PULL, 8'h00, `PBPU_RESP_OKAY);
		pins(8'h00, 8'h00);
		wr(`PBPU_ADDR_DIR, 8'hff, `PBPU_RESP_OKAY);
		pins(8'h00, 8'hff);
		wr(`PBPU_ADDR_DIR, 8'h00, `PBPU_RESP_OKAY);
	endtask : t_off

	// latch writes against inputs, mixed readback
	task automatic t_data();
		PB_IN <= 8'h3c;
		wr(`PBPU_ADDR_DATA, 8'hff, `PBPU_RESP_OKAY);
		rd(`PBPU_ADDR_DATA, 8'h3c, `PBPU_RESP_OKAY);
		chk8("latch pins", PB_OUT, 8'hff);
		wr(`PBPU_ADDR_DIR, 8'h0f, `PBPU_RESP_OKAY);
		rd(`PBPU_ADDR_DATA, 8'h3f, `PBPU_RESP_OKAY);
		wr(`PBPU_ADDR_DATA, 8'ha5, `PBPU_RESP_OKAY);
		rd(`PBPU_ADDR_DATA, 8'h35, `PBPU_RESP_OKAY);
		pins(8'h00, 8'h0f);
	endtask : t_data

	// unmapped address refused, enables untouched
	task automatic t_unmapped();
		wr(8'h08, 8'hff, `PBPU_RESP_SLVERR);
		rd(8'h08, 8'h00, `PBPU_RESP_SLVERR);
		strb_sel = 4'he;
		wr(`PBPU_ADDR_PULL, 8'hff, `PBPU_RESP_OKAY);
		strb_sel = 4'hf;
		rd(`PBPU_ADDR_PULL, 8'h00, `PBPU_RESP_OKAY);
	endtask : t_unmapped

	// mid-run reset with the enable low clears enables, latch and pins
	task automatic t_rerun();
		wr(`PBPU_ADDR_PULL, 8'hff, `PBPU_RESP_OKAY);
		pins(8'hf0, 8'h0f);
		@(posedge CLK);
		CE <= 1'b0;
		SRST <= 1'b1;
		repeat (2) @(posedge CLK);
		@(negedge CLK);
		chk8("readies frozen", {5'h00, AWREADY, WREADY, ARREADY}, 8'h00);
		@(posedge CLK);
		SRST <= 1'b0;
		CE <= 1'b1;
		pins(8'h00, 8'h00);
		chk8("latch after reset", PB_OUT, 8'h00);
		rd(`PBPU_ADDR_PULL, 8'h00, `PBPU_RESP_OKAY);
	endtask : t_rerun

	// counts, verdict and end of run
	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// main sequence
	initial begin
		repeat (2) @(posedge CLK);
		SRST <= 1'b0;
		t_reset();
		t_bits();
		t_dir();
		t_off();
		t_data();
		t_unmapped();
		t_rerun();
		final_report();
	end

	// watchdog: the run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge CLK);
		miscompares++;
		final_report();
	end
endmodule : test_port_b_pullup_control
